// ===== fpm_pkg.sv
// Shared constants, types and register map of the front panel menu editor
package fpm_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 40000;
  localparam int HOLD_MS = 3000;
  localparam int ABBR_MS = 2000;
  localparam int BLINK_MS = 250;
  localparam int DEB_US = 500;
  localparam int HOLD_CYC = HOLD_MS * CLK_KHZ;
  localparam int ABBR_CYC = ABBR_MS * CLK_KHZ;
  localparam int BLINK_CYC = BLINK_MS * CLK_KHZ;
  localparam int DEB_CYC = (DEB_US * CLK_KHZ) / 1000;

  // ----------------------------------------------------------------
  // Menu and arithmetic
  // ----------------------------------------------------------------
  localparam logic [2:0] SCR_SCALE = 3'h6;
  localparam logic [2:0] SCR_LAST = 3'h7;
  localparam logic [2:0] CUR_LAST = 3'h4;
  localparam logic [2:0] DP_MAX = 3'h5;
  localparam logic [2:0] DP_RESET = 3'h3;
  localparam logic [3:0] DIG_MAX = 4'h9;
  localparam int ADC_COUNTS = 20000;
  localparam int NKEY = 6;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_PARAM0 = 8'h00;
  localparam logic [7:0] OFF_DP = 8'h1c;
  localparam logic [7:0] OFF_STAT = 8'h20;
  localparam logic [7:0] OFF_CTRL = 8'h24;
  localparam logic [7:0] OFF_APPLIED = 8'h28;
  localparam logic [15:0] FS_REF_MV = 16'h2710;

  typedef enum logic [1:0] {ST_READ, ST_ABBR, ST_VAL} fpm_state_e;

  // Sign plus five BCD digits, leftmost digit in the top nibble
  typedef struct packed {
    logic neg;
    logic [19:0] bcd;
  } fpm_val_s;

  localparam fpm_val_s V_SPH = '{neg: 1'b0, bcd: 20'h11000};
  localparam fpm_val_s V_SPL = '{neg: 1'b1, bcd: 20'h11000};
  localparam fpm_val_s V_HYS = '{neg: 1'b0, bcd: 20'h00020};
  localparam fpm_val_s V_SCALE = '{neg: 1'b0, bcd: 20'h10000};

  typedef struct packed {
    logic menu;
    logic up;
    logic right;
    logic zero;
    logic full_scale;
    logic remote_zero_n;
  } fpm_keys_s;

  typedef struct packed {
    fpm_state_e mode;
    logic [2:0] screen;
    fpm_val_s value;
    logic [2:0] cursor;
    logic digit_hidden;
    logic sign_lamp;
    logic [2:0] decimal_position;
    logic full_scale_trim_active;
    logic signed [31:0] reading;
  } fpm_disp_s;

endpackage : fpm_pkg

// ===== fpm_menu_editor.sv
// Front panel keypad and menu editor with APB register access
//
// How it works
// - Menu key steps eight screens in fixed order.
// - Each screen shows its abbreviation for a while, then the value.
// - Once scrolling begins, reading returns only after the last screen.
// - Selected digit blinks; menu accepts value and advances.
// - Up key adds one to the selected digit, 0 to 9.
// - Leftmost digit steps 0..9 then -0..-9, twenty states.
// - Sign lamp off when positive, flashes with leftmost digit if negative.
// - Right key moves cursor one digit right; new digit blinks.
// - On decimal screen up moves decimal point one place left.
// - On decimal screen each up press stores the position at once; menu returns to reading.
// - Zero key held three seconds zeroes; shorter holds do nothing.
// - Zero offsets only the displayed reading.
// - Remote zero held low three seconds gives the same zero.
// - Keypad scale count accepted only within 1 to 99999; APB writes are stored unchecked.
// - Displayed step equals scale count over 20000.
// - New scale count stored at once, applied at full-scale calibration.
// - Decimal point shown on scale screen but ignored for value.
// - Scale count defaults to +10000, full-scale reference 10 V.
// - Decimal position has six settings, five decimals to none.
// - Full-scale key held three seconds toggles calibration and lamp.
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module fpm_menu_editor #(
  parameter int HOLD_CYC = fpm_pkg::HOLD_CYC,
  parameter int ABBR_CYC = fpm_pkg::ABBR_CYC,
  parameter int BLINK_CYC = fpm_pkg::BLINK_CYC,
  parameter int DEB_CYC = fpm_pkg::DEB_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire fpm_pkg::fpm_keys_s keys,
  input wire logic signed [17:0] adc_counts,
  output fpm_pkg::fpm_disp_s disp
);

  // ----------------------------------------------------------------
  // Key debounce and edge detect
  // ----------------------------------------------------------------
  logic [fpm_pkg::NKEY-1:0] raw_w;
  logic [fpm_pkg::NKEY-1:0] db_ff;
  logic [fpm_pkg::NKEY-1:0] db_q_ff;
  logic [fpm_pkg::NKEY-1:0] ev_w;
  logic keys_off_ff;
  // Remote zero is active low, so invert it into a common press level
  assign raw_w = {keys.menu, keys.up, keys.right, keys.zero, keys.full_scale, ~keys.remote_zero_n};

  for (genvar k = 0; k < fpm_pkg::NKEY; k++) begin : g_deb
    logic [31:0] cnt_ff;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_ff <= '0;
        db_ff[k] <= 1'b0;
      end else if (raw_w[k] == db_ff[k]) begin
        cnt_ff <= '0;
      end else if (cnt_ff == DEB_CYC - 1) begin
        cnt_ff <= '0;
        db_ff[k] <= raw_w[k];
      end else begin
        cnt_ff <= cnt_ff + 32'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) db_q_ff <= '0;
    else db_q_ff <= db_ff;
  end
  // one step per press; control register can lock the panel
  assign ev_w = db_ff & ~db_q_ff & {fpm_pkg::NKEY{~keys_off_ff}};

  logic menu_ev;
  logic up_ev;
  logic right_ev;
  assign menu_ev = ev_w[5];
  assign up_ev = ev_w[4];
  assign right_ev = ev_w[3];

  // ----------------------------------------------------------------
  // Long hold timers for zero and full scale
  // ----------------------------------------------------------------
  logic zero_held;
  logic fs_held;
  logic [31:0] zero_cnt_ff;
  logic [31:0] fs_cnt_ff;
  logic zero_fire;
  logic fs_fire;
  // remote zero shares the front panel zero timer
  assign zero_held = (db_ff[2] | db_ff[0]) & ~keys_off_ff;
  assign fs_held = db_ff[1] & ~keys_off_ff;
  // Saturating counters fire once per hold
  assign zero_fire = zero_held && (zero_cnt_ff == HOLD_CYC - 1);
  assign fs_fire = fs_held && (fs_cnt_ff == HOLD_CYC - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_cnt_ff <= '0;
      fs_cnt_ff <= '0;
    end else begin
      zero_cnt_ff <= !zero_held ? '0 : (zero_cnt_ff < HOLD_CYC ? zero_cnt_ff + 32'h1 : zero_cnt_ff);
      fs_cnt_ff <= !fs_held ? '0 : (fs_cnt_ff < HOLD_CYC ? fs_cnt_ff + 32'h1 : fs_cnt_ff);
    end
  end

  // ----------------------------------------------------------------
  // Menu state machine and edit buffer
  // ----------------------------------------------------------------
  fpm_pkg::fpm_state_e st_ff;
  fpm_pkg::fpm_state_e nxt_st;
  logic [2:0] scr_ff;
  logic [2:0] cur_ff;
  logic [31:0] abbr_cnt_ff;
  fpm_pkg::fpm_val_s ed_ff;
  fpm_pkg::fpm_val_s prm_ff [7];
  logic [2:0] dp_ff;
  logic in_val;
  logic accept;
  logic last_scr;
  logic [3:0] sel_dig;
  logic [2:0] sh;
  logic [16:0] ed_bin;
  logic scale_ok;
  fpm_pkg::fpm_val_s ed_up;

  assign in_val = (st_ff == fpm_pkg::ST_VAL);
  assign last_scr = (scr_ff == fpm_pkg::SCR_LAST);
  // Menu during the abbreviation accepts the unchanged value too
  assign accept = menu_ev && (st_ff != fpm_pkg::ST_READ);
  assign sh = 3'(fpm_pkg::CUR_LAST - cur_ff);
  assign sel_dig = ed_ff.bcd[sh*4 +: 4];

  // decimal point plays no part in the scale count
  function automatic logic [16:0] bcd2bin(input logic [19:0] b);
    logic [16:0] r;
    r = '0;
    for (int i = 4; i >= 0; i--) begin
      r = 17'(r * 17'd10 + 17'(b[i*4 +: 4]));
    end
    return r;
  endfunction
  // scale digits read as an integer whatever the point
  assign ed_bin = bcd2bin(ed_ff.bcd);
  // zero or negative scale counts are refused
  assign scale_ok = !ed_ff.neg && (ed_bin != 17'h0);

  always_comb begin
    ed_up = ed_ff;
    if (sel_dig != fpm_pkg::DIG_MAX) begin
      ed_up.bcd[sh*4 +: 4] = sel_dig + 4'h1;
    end else begin
      ed_up.bcd[sh*4 +: 4] = 4'h0;
      // leftmost digit wraps into the other sign
      if (cur_ff == 3'h0) ed_up.neg = ~ed_ff.neg;
    end
  end

  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      fpm_pkg::ST_READ: if (menu_ev) nxt_st = fpm_pkg::ST_ABBR;
      fpm_pkg::ST_ABBR: begin
        if (menu_ev) nxt_st = last_scr ? fpm_pkg::ST_READ : fpm_pkg::ST_ABBR;
        else if (abbr_cnt_ff == ABBR_CYC - 1) nxt_st = fpm_pkg::ST_VAL;
      end
      // reading only after the last screen
      fpm_pkg::ST_VAL: if (menu_ev) nxt_st = last_scr ? fpm_pkg::ST_READ : fpm_pkg::ST_ABBR;
    endcase
  end

  // Screen, timer and cursor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= fpm_pkg::ST_READ;
      scr_ff <= '0;
      cur_ff <= '0;
      abbr_cnt_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      abbr_cnt_ff <= (nxt_st == fpm_pkg::ST_ABBR && !menu_ev) ? abbr_cnt_ff + 32'h1 : '0;
      if (st_ff == fpm_pkg::ST_READ && menu_ev) scr_ff <= '0;
      else if (accept && !last_scr) scr_ff <= scr_ff + 3'h1;
      if (menu_ev) cur_ff <= '0;
      // cursor one step right, wraps after the last digit
      else if (in_val && right_ev) cur_ff <= (cur_ff == fpm_pkg::CUR_LAST) ? 3'h0 : cur_ff + 3'h1;
    end
  end

  // Edit buffer loads the stored value when the abbreviation of screens 0 to 6 gives way to its value; the last screen loads nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ed_ff <= '0;
    else if (st_ff == fpm_pkg::ST_ABBR && nxt_st == fpm_pkg::ST_VAL && !last_scr) ed_ff <= prm_ff[scr_ff];
    else if (in_val && up_ev && !last_scr) ed_ff <= ed_up;
  end

  // ----------------------------------------------------------------
  // Stored configuration and APB writes
  // ----------------------------------------------------------------
  logic apb_wr;
  logic apb_rd_setup;
  logic [2:0] widx;
  logic hit_prm;
  logic hit_known;
  assign apb_wr = psel && penable && pready && pwrite;
  assign apb_rd_setup = psel && !penable;
  assign widx = paddr[4:2];
  assign hit_prm = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
  assign hit_known = hit_prm || paddr == fpm_pkg::OFF_STAT || paddr == fpm_pkg::OFF_CTRL
                     || paddr == fpm_pkg::OFF_APPLIED;

  for (genvar p = 0; p < 7; p++) begin : g_prm
    // Factory value of this slot: thresholds alternate sign, then margins, then scale
    localparam fpm_pkg::fpm_val_s RST_V = (p == 6) ? fpm_pkg::V_SCALE : (p >= 4) ? fpm_pkg::V_HYS
                                         : (((p % 2) == 1) ? fpm_pkg::V_SPL : fpm_pkg::V_SPH);
    logic take_ed;
    // menu accepts the whole edited value
    assign take_ed = in_val && menu_ev && scr_ff == 3'(p) && (p != 6 || scale_ok);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prm_ff[p] <= RST_V;
      else if (take_ed) prm_ff[p] <= ed_ff;
      else if (apb_wr && hit_prm && widx == 3'(p)) prm_ff[p] <= pwdata[20:0];
    end
  end

  // decimal point steps left, six settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) dp_ff <= fpm_pkg::DP_RESET;
    else if (in_val && last_scr && up_ev) dp_ff <= (dp_ff == fpm_pkg::DP_MAX) ? 3'h0 : dp_ff + 3'h1;
    else if (apb_wr && paddr == fpm_pkg::OFF_DP && pwdata[2:0] <= fpm_pkg::DP_MAX) dp_ff <= pwdata[2:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) keys_off_ff <= 1'b0;
    else if (apb_wr && paddr == fpm_pkg::OFF_CTRL) keys_off_ff <= pwdata[0];
  end

  // ----------------------------------------------------------------
  // Full scale calibration, zero and reading
  // ----------------------------------------------------------------
  logic fs_on_ff;
  logic [16:0] scale_app_ff;
  logic signed [31:0] zero_off_ff;
  logic signed [35:0] prod;
  logic signed [31:0] pre_zero;
  assign prod = adc_counts * $signed({1'b0, scale_app_ff});
  // step is scale count over converter counts
  assign pre_zero = fs_on_ff ? 32'(prod / fpm_pkg::ADC_COUNTS) : 32'(adc_counts);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs_on_ff <= 1'b1;
      scale_app_ff <= 17'(fpm_pkg::V_SCALE.bcd >> 16) * 17'd10000;
      zero_off_ff <= '0;
    end else begin
      // toggle calibration on a long hold
      if (fs_fire) fs_on_ff <= ~fs_on_ff;
      // stored scale applied only at calibration
      if (fs_fire && !fs_on_ff) scale_app_ff <= bcd2bin(prm_ff[fpm_pkg::SCR_SCALE].bcd);
      // offset applies to the display only
      if (zero_fire) zero_off_ff <= pre_zero;
    end
  end

  // ----------------------------------------------------------------
  // Display drive
  // ----------------------------------------------------------------
  logic [31:0] blink_cnt_ff;
  logic blink_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt_ff <= '0;
      blink_ff <= 1'b0;
    end else if (blink_cnt_ff == BLINK_CYC - 1) begin
      blink_cnt_ff <= '0;
      blink_ff <= ~blink_ff;
    end else begin
      blink_cnt_ff <= blink_cnt_ff + 32'h1;
    end
  end

  // All display fields are registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp <= '0;
    end else begin
      disp.mode <= st_ff;
      disp.screen <= scr_ff;
      disp.value <= ed_ff;
      disp.cursor <= cur_ff;
      disp.digit_hidden <= in_val && blink_ff;
      // lamp flashes with the leftmost digit when negative
      disp.sign_lamp <= in_val && ed_ff.neg && !(cur_ff == 3'h0 && blink_ff);
      // point still shown on the scale screen
      disp.decimal_position <= dp_ff;
      disp.full_scale_trim_active <= fs_on_ff;
      disp.reading <= pre_zero - zero_off_ff;
    end
  end

  // ----------------------------------------------------------------
  // APB read and answer, no wait state
  // ----------------------------------------------------------------
  logic [31:0] rd_w;
  // Status bit 2 is a spare so that the screen field sits on bits 5:3
  assign rd_w = hit_prm ? (widx == 3'h7 ? {29'h0, dp_ff} : {11'h0, prm_ff[widx]})
              : paddr == fpm_pkg::OFF_STAT ? {fpm_pkg::FS_REF_MV, 6'h0, fs_on_ff, cur_ff, scr_ff, 1'b0, st_ff}
              : paddr == fpm_pkg::OFF_CTRL ? {31'h0, keys_off_ff}
              : paddr == fpm_pkg::OFF_APPLIED ? {15'h0, scale_app_ff} : 32'h0;

  // Answer always one cycle after setup: no stall logic, but no slow register either
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= apb_rd_setup;
      pslverr <= apb_rd_setup && !hit_known;
      if (apb_rd_setup) prdata <= rd_w;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_enter_abbr;
    st_ff == fpm_pkg::ST_ABBR && !menu_ev;
  endsequence

  a_menu_first_scr: assert property (st_ff == fpm_pkg::ST_READ && menu_ev |=> st_ff == fpm_pkg::ST_ABBR && scr_ff == 3'h0) else $error("menu entry wrong");
  a_screen_next: assert property (accept && !last_scr |=> scr_ff == $past(scr_ff) + 3'h1) else $error("screen step wrong");
  a_abbr_hold: assert property ($rose(st_ff == fpm_pkg::ST_ABBR) ##0 !menu_ev |=> s_enter_abbr [*2]) else $error("value shown early");
  a_no_early_exit: assert property (st_ff != fpm_pkg::ST_READ && !(menu_ev && last_scr) |=> st_ff != fpm_pkg::ST_READ) else $error("left menu early");
  a_last_exits: assert property (accept && last_scr |=> st_ff == fpm_pkg::ST_READ) else $error("no exit after last");
  a_cursor_step: assert property (in_val && right_ev && !menu_ev && cur_ff < fpm_pkg::CUR_LAST |=> cur_ff == $past(cur_ff) + 3'h1) else $error("cursor step wrong");
  a_sign_off: assert property (in_val && !ed_ff.neg |=> !disp.sign_lamp) else $error("sign lamp lit");
  a_zero_hold: assert property ($changed(zero_off_ff) |-> $past(zero_held && zero_cnt_ff == HOLD_CYC - 1)) else $error("zero too soon");
  a_scale_valid: assert property (prm_ff[fpm_pkg::SCR_SCALE] != $past(prm_ff[fpm_pkg::SCR_SCALE]) && !$past(apb_wr) |-> !prm_ff[fpm_pkg::SCR_SCALE].neg && prm_ff[fpm_pkg::SCR_SCALE].bcd != 20'h0) else $error("bad scale kept");
  a_scale_late: assert property (!fs_fire |=> $stable(scale_app_ff)) else $error("scale applied early");
  a_apb_answer: assert property (psel && !penable |=> pready) else $error("no answer");
  a_cursor_home: assert property (menu_ev |=> cur_ff == 3'h0) else $error("cursor not leftmost");
  a_dp_range: assert property (dp_ff <= fpm_pkg::DP_MAX) else $error("decimal position out of range");
  a_keys_locked: assert property (keys_off_ff |-> ev_w == '0) else $error("locked key acted");

endmodule : fpm_menu_editor

// ===== fpm_panel_model.sv
// Operator keypad, remote zero contact and converter feed for the menu editor
`timescale 1ns/100ps
module fpm_panel_model (
  input wire logic pclk,
  output fpm_pkg::fpm_keys_s keys,
  output logic signed [17:0] adc_counts
);
  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  // Remote zero idles high through its pull-up, so an open contact reads released
  initial begin
    keys = '{remote_zero_n: 1'b1, default: 1'b0};
    adc_counts = 18'sh0;
  end

  // ----------------------------------------------------------------
  // Operator actions
  // ----------------------------------------------------------------
  // continuous hold time
  // One press held for hold cycles; the long gap after it lets debounce settle
  task automatic press(input int idx, input int hold);
    logic [5:0] mask;
    mask = 6'h01 << idx;
    @(posedge pclk);
    keys <= fpm_pkg::fpm_keys_s'(keys ^ mask);
    repeat (hold) @(posedge pclk);
    keys <= fpm_pkg::fpm_keys_s'(keys ^ mask);
    repeat (10) @(posedge pclk);
  endtask : press

  // Converter counts change only at a clock edge
  task automatic set_adc(input logic signed [17:0] v);
    @(posedge pclk);
    adc_counts <= v;
    repeat (4) @(posedge pclk);
  endtask : set_adc
endmodule : fpm_panel_model

// ===== fpm_menu_editor_tb.sv
// Self-checking bench of the front panel menu editor
`timescale 1ns/100ps
module fpm_menu_editor_tb;
  localparam int K_MENU = 5;
  localparam int K_UP = 4;
  localparam int K_RIGHT = 3;
  localparam int K_ZERO = 2;
  localparam int K_FS = 1;
  localparam int K_RZ = 0;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  fpm_pkg::fpm_keys_s keys;
  logic signed [17:0] adc_counts;
  fpm_pkg::fpm_disp_s disp;
  int n_mismatch, check_count, cyc;
  logic [31:0] dflt [7] = '{32'h011000, 32'h111000, 32'h011000, 32'h111000, 32'h000020, 32'h000020, 32'h010000};

  // Short counts keep holds and abbreviations to a few dozen cycles
  fpm_menu_editor #(.HOLD_CYC(40), .ABBR_CYC(40), .BLINK_CYC(4), .DEB_CYC(2)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .keys(keys), .adc_counts(adc_counts), .disp(disp));
  fpm_panel_model i_panel (.pclk(pclk), .keys(keys), .adc_counts(adc_counts));

  // ----------------------------------------------------------------
  // Clock, timeout and verdict
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  // A hang is cut after far more cycles than the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Request is held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ee);
    logic [31:0] q;
    logic er;
    apb(1'b0, a, 32'h0, q, er);
    chk("pslverr", {31'h0, ee}, {31'h0, er});
    if (!ee) chk("prdata", e, q);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic er;
    apb(1'b1, a, d, q, er);
    chk("pslverr", 32'h0, {31'h0, er});
  endtask : wr

  task automatic tap(input int k);
    i_panel.press(k, 6);
  endtask : tap

  task automatic wait_val();
    int n;
    n = 0;
    while (disp.mode !== fpm_pkg::ST_VAL && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk("mode", 32'(fpm_pkg::ST_VAL), 32'(disp.mode));
    chk("cursor", 32'h0, 32'(disp.cursor));
  endtask : wait_val

  // Lamp follows the leftmost digit blink when negative, stays dark when positive
  task automatic lamp(input logic neg);
    repeat (8) begin
      @(posedge pclk);
      chk("sign_lamp", {31'h0, neg & ~disp.digit_hidden}, {31'h0, disp.sign_lamp});
    end
  endtask : lamp

  task automatic scr(input int s, input fpm_pkg::fpm_state_e m);
    chk("screen", 32'(s), 32'(disp.screen));
    chk("mode", 32'(m), 32'(disp.mode));
  endtask : scr

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Defaults after reset, then an unmapped access
    for (int i = 0; i < 7; i++) rd(8'(4 * i), dflt[i], 1'b0);
    rd(8'h1c, 32'h3, 1'b0);
    rd(8'h20, 32'h27100200, 1'b0);
    rd(8'h28, 32'h2710, 1'b0);
    rd(8'h2c, 32'h0, 1'b1);
    chk("fs lamp", 32'h1, 32'(disp.full_scale_trim_active));
    $display("test reset finished");
    // First screen: abbreviation, value, digit edits
    tap(K_MENU);
    scr(0, fpm_pkg::ST_ABBR);
    wait_val();
    chk("value", 32'h011000, 32'(disp.value));
    lamp(1'b0);
    tap(K_UP);
    chk("value", 32'h021000, 32'(disp.value));
    tap(K_RIGHT);
    chk("cursor", 32'h1, 32'(disp.cursor));
    tap(K_UP);
    chk("value", 32'h022000, 32'(disp.value));
    tap(K_MENU);
    scr(1, fpm_pkg::ST_ABBR);
    rd(8'h00, 32'h022000, 1'b0);
    wait_val();
    lamp(1'b1);
    $display("test edit finished");
    // Remaining screens stay in the menu until the last one
    for (int s = 2; s < 7; s++) begin
      tap(K_MENU);
      scr(s, fpm_pkg::ST_ABBR);
    end
    wait_val();
    repeat (9) tap(K_UP);
    chk("value", 32'h100000, 32'(disp.value));
    tap(K_MENU);
    scr(7, fpm_pkg::ST_ABBR);
    rd(8'h18, 32'h010000, 1'b0);
    wait_val();
    tap(K_UP);
    chk("decimal", 32'h4, 32'(disp.decimal_position));
    tap(K_MENU);
    chk("mode", 32'(fpm_pkg::ST_READ), 32'(disp.mode));
    rd(8'h1c, 32'h4, 1'b0);
    // Locked panel ignores keys; out of range point writes are refused
    wr(8'h24, 32'h1);
    rd(8'h24, 32'h1, 1'b0);
    tap(K_MENU);
    chk("mode", 32'(fpm_pkg::ST_READ), 32'(disp.mode));
    wr(8'h24, 32'h0);
    wr(8'h1c, 32'h7);
    rd(8'h1c, 32'h4, 1'b0);
    $display("test menu finished");
    // New scale waits for full-scale calibration
    wr(8'h18, 32'h030000);
    rd(8'h28, 32'h2710, 1'b0);
    i_panel.set_adc(18'sd1000);
    chk("reading", 32'd500, disp.reading);
    i_panel.press(K_FS, 60);
    chk("fs lamp", 32'h0, 32'(disp.full_scale_trim_active));
    chk("reading", 32'd1000, disp.reading);
    i_panel.press(K_FS, 60);
    chk("fs lamp", 32'h1, 32'(disp.full_scale_trim_active));
    rd(8'h28, 32'h7530, 1'b0);
    chk("reading", 32'd1500, disp.reading);
    $display("test scale finished");
    // Short and long zero holds, then remote zero
    i_panel.press(K_ZERO, 20);
    chk("reading", 32'd1500, disp.reading);
    i_panel.press(K_ZERO, 60);
    chk("reading", 32'd0, disp.reading);
    i_panel.set_adc(18'sd1400);
    chk("reading", 32'd600, disp.reading);
    i_panel.press(K_RZ, 60);
    chk("reading", 32'd0, disp.reading);
    $display("test zero finished");
    report_and_stop();
  end
endmodule : fpm_menu_editor_tb
